// ===== hdl/bcr_pkg.sv
// bcr_pkg: shared constants and types of the bridge configuration header and command block
package bcr_pkg;

    // access types, one-hot; ROP, RWP and RWCP survive a hot reset
    typedef enum logic [5:0] {
        ACC_RO   = 6'h01,
        ACC_ROP  = 6'h02,
        ACC_RW   = 6'h04,
        ACC_RWC  = 6'h08,
        ACC_RWP  = 6'h10,
        ACC_RWCP = 6'h20
    } bcr_acc_t;

    // configuration byte offsets, dword aligned
    localparam logic [11:0] OFF_IDENT   = 12'h000;
    localparam logic [11:0] OFF_COMMAND = 12'h004;

    // identification field positions
    localparam int VENDOR_LSB  = 0;
    localparam int PRODUCT_LSB = 16;

    // command field positions
    localparam int CMD_W          = 9;
    localparam int CMD_IO_EN      = 0;
    localparam int CMD_MEM_EN     = 1;
    localparam int CMD_MASTER_EN  = 2;
    localparam int CMD_SPECIAL    = 3;
    localparam int CMD_MWI        = 4;
    localparam int CMD_VGA_SNOOP  = 5;
    localparam int CMD_PARITY_RSP = 6;
    localparam int CMD_WAIT_CYC   = 7;
    localparam int CMD_SYSERR_EN  = 8;

    // master data parity error status position in the dword at 04h
    localparam int STAT_MDPE_BIT = 24;

    // reset values
    localparam logic [CMD_W-1:0] CMD_RST  = 9'h000;
    localparam logic             MDPE_RST = 1'h0;

    // access type of each command bit
    localparam bcr_acc_t CMD_ACC [CMD_W] = '{
        ACC_RW, ACC_RW, ACC_RW, ACC_RO, ACC_RO, ACC_RW, ACC_RW, ACC_RO, ACC_RW
    };

    // vga palette i/o addresses, low ten address bits only
    localparam logic [9:0] VGA_PAL_A = 10'h3C6;
    localparam logic [9:0] VGA_PAL_B = 10'h3C8;
    localparam logic [9:0] VGA_PAL_C = 10'h3C9;

    // configuration transaction from the primary interface
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bcr_cfg_req_t;

    // configuration answer
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } bcr_cfg_rsp_t;

    // decode and master enables handed to the bridge core
    typedef struct packed {
        logic io_target_en;
        logic mem_read_en;
        logic primary_master_en;
        logic secondary_target_en;
        logic split_cpl_en;
        logic parity_rsp_en;
    } bcr_ctrl_t;

endpackage

// ===== hdl/bcr_field.sv
// bcr_field: one configuration field of selectable access type
`timescale 1ns/1ps
`default_nettype none
module bcr_field #(
    parameter int                       W   = 1,
    parameter bcr_pkg::bcr_acc_t        ACC = bcr_pkg::ACC_RW,
    parameter logic [W-1:0]             RST = '0
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   hot_rst_i,
    input  wire logic [W-1:0]           wmask_i,
    input  wire logic [W-1:0]           wdata_i,
    input  wire logic [W-1:0]           set_i,
    output logic      [W-1:0]           q_o
);
    import bcr_pkg::*;

    typedef struct packed {
        logic [W-1:0] val;
    } bcr_field_st_t;

    localparam bit STICKY = (ACC == ACC_ROP) || (ACC == ACC_RWP) || (ACC == ACC_RWCP);

    bcr_field_st_t st;
    bcr_field_st_t next_st;

    generate
        if (W < 1) begin : g_bad_width
            $error("bcr_field width must be at least one");
        end
    endgenerate

    // next value by access type; hardware set beats a same-cycle clear
    always_comb begin
        next_st = st;
        case (ACC)
            ACC_RO:           next_st.val = RST;
            ACC_ROP:          next_st.val = set_i;
            ACC_RW, ACC_RWP:  next_st.val = (wdata_i & wmask_i) | (st.val & ~wmask_i);
            ACC_RWC, ACC_RWCP: next_st.val = (st.val & ~(wdata_i & wmask_i)) | set_i;
            default:          next_st.val = RST;
        endcase
        // sticky fields ride through a hot reset, others fall back
        if (hot_rst_i && !STICKY) begin
            next_st.val = RST;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st.val <= RST;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.val;
endmodule
`default_nettype wire

// ===== hdl/bcr_config.sv
// bcr_config: transparent-mode identification and command registers of the bridge
`timescale 1ns/1ps
`default_nettype none
// How it works
// - writing one clears a write-one-clear bit
// - sticky variants of RO, RW, W1C exist
// - low half of dword 00h: fixed vendor code
// - high half of dword 00h: fixed product code
// - io enable gates primary io target response
// - memory enable gates primary memory read acceptance
// - master enable off blocks primary mastering, secondary response
// - split completions allowed in reverse pci-x mode
// - special cycle bit reads zero, read only
// - write-and-invalidate bit reads zero, read only
// - palette snoop writable reverse only, decodes palette
// - parity response sets master parity error status
// - wait cycle bit reads zero, read only
// - error enable sends forward error messages
// - error enable drives system error pin reverse
module bcr_config #(
    parameter logic [15:0]              VENDOR_CODE  = 16'h1A2B,  // arbitrary value
    parameter logic [15:0]              PRODUCT_CODE = 16'h3C4D   // arbitrary value
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   hot_rst_i,
    input  wire bcr_pkg::bcr_cfg_req_t  cfg_req_i,
    output bcr_pkg::bcr_cfg_rsp_t       cfg_rsp_o,
    input  wire logic                   reverse_mode_i,
    input  wire logic                   pcix_mode_i,
    input  wire logic                   vga_io_write_i,
    input  wire logic [9:0]             vga_io_addr_i,
    output logic                        vga_palette_hit_o,
    input  wire logic                   parity_event_i,
    input  wire logic                   error_event_i,
    input  wire logic                   error_fatal_i,
    output logic                        error_msg_o,
    output logic                        error_msg_fatal_o,
    output logic                        system_error_out_n_o,
    output logic                        system_error_oe_o,
    output bcr_pkg::bcr_ctrl_t          ctrl_o
);
    import bcr_pkg::*;

    typedef struct packed {
        logic         rev_meta;
        logic         rev_sync;
        logic         pcix_meta;
        logic         pcix_sync;
        bcr_cfg_rsp_t rsp;
        logic         msg;
        logic         msg_fatal;
        logic         serr_n;
    } bcr_cfg_st_t;

    bcr_cfg_st_t      st;
    bcr_cfg_st_t      next_st;
    logic [31:0]      wmask;
    logic             cmd_hit;
    logic [CMD_W-1:0] cmd_wmask;
    logic [CMD_W-1:0] cmd;
    logic             mdpe;
    logic             mdpe_set;
    logic [31:0]      rd_word;

    // byte enables widen to a bit mask; only a write to the command dword touches it
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{cfg_req_i.be[b]}};
        end
        cmd_hit = cfg_req_i.valid && cfg_req_i.write && (cfg_req_i.addr[11:2] == OFF_COMMAND[11:2]);
        cmd_wmask = cmd_hit ? wmask[CMD_W-1:0] : '0;
        // palette snoop bit only takes writes in reverse mode
        if (!st.rev_sync) begin
            cmd_wmask[CMD_VGA_SNOOP] = 1'b0;
        end
    end

    // one cell per command bit, access type from the table
    generate
        for (genvar i = 0; i < CMD_W; i++) begin : g_cmd
            bcr_field #(
                .W   (1),
                .ACC (CMD_ACC[i]),
                .RST (CMD_RST[i])
            ) u_bit (
                .clk_i     (clk_i),
                .rst_n_i   (rst_n_i),
                .hot_rst_i (hot_rst_i),
                .wmask_i   (cmd_wmask[i]),
                .wdata_i   (cfg_req_i.wdata[i]),
                .set_i     (1'b0),
                .q_o       (cmd[i])
            );
        end
    endgenerate

    // parity events latch only while parity response is enabled
    assign mdpe_set = parity_event_i && cmd[CMD_PARITY_RSP];

    bcr_field #(
        .W   (1),
        .ACC (ACC_RWC),
        .RST (MDPE_RST)
    ) u_mdpe (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .hot_rst_i (hot_rst_i),
        .wmask_i   (cmd_hit && cfg_req_i.be[STAT_MDPE_BIT/8]),
        .wdata_i   (cfg_req_i.wdata[STAT_MDPE_BIT]),
        .set_i     (mdpe_set),
        .q_o       (mdpe)
    );

    // read mux; unmapped dwords and unimplemented bits read zero
    always_comb begin
        rd_word = 32'h0000_0000;
        case (cfg_req_i.addr[11:2])
            OFF_IDENT[11:2]: begin
                rd_word[VENDOR_LSB  +: 16] = VENDOR_CODE;
                rd_word[PRODUCT_LSB +: 16] = PRODUCT_CODE;
            end
            OFF_COMMAND[11:2]: begin
                rd_word[CMD_W-1:0]    = cmd;
                rd_word[STAT_MDPE_BIT] = mdpe;
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // strap sync, answer register and error reporting
    always_comb begin
        next_st = st;
        // mode straps come from pins, so two flops before any use
        next_st.rev_meta  = reverse_mode_i;
        next_st.rev_sync  = st.rev_meta;
        next_st.pcix_meta = pcix_mode_i;
        next_st.pcix_sync = st.pcix_meta;
        // every request is answered one cycle later; writes return zero data
        next_st.rsp.ack   = cfg_req_i.valid;
        next_st.rsp.rdata = (cfg_req_i.valid && !cfg_req_i.write) ? rd_word : 32'h0000_0000;
        // errors go upstream as messages forward, on the pin in reverse
        next_st.msg       = error_event_i && cmd[CMD_SYSERR_EN] && !st.rev_sync;
        next_st.msg_fatal = error_event_i && error_fatal_i && cmd[CMD_SYSERR_EN] && !st.rev_sync;
        next_st.serr_n    = !(error_event_i && cmd[CMD_SYSERR_EN] && st.rev_sync);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st.rev_meta  <= 1'b0;
            st.rev_sync  <= 1'b0;
            st.pcix_meta <= 1'b0;
            st.pcix_sync <= 1'b0;
            st.rsp       <= '0;
            st.msg       <= 1'b0;
            st.msg_fatal <= 1'b0;
            st.serr_n    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // enables follow the command bits directly so the core sees a write next cycle
    always_comb begin
        ctrl_o.io_target_en        = cmd[CMD_IO_EN];
        ctrl_o.mem_read_en         = cmd[CMD_MEM_EN];
        ctrl_o.primary_master_en   = cmd[CMD_MASTER_EN];
        ctrl_o.secondary_target_en = cmd[CMD_MASTER_EN];
        ctrl_o.split_cpl_en        = cmd[CMD_MASTER_EN] || (st.rev_sync && st.pcix_sync);
        ctrl_o.parity_rsp_en       = cmd[CMD_PARITY_RSP];
    end

    // palette decode ignores address bits above nine, isa aliases included
    assign vga_palette_hit_o = cmd[CMD_VGA_SNOOP] && st.rev_sync && vga_io_write_i &&
                               ((vga_io_addr_i == VGA_PAL_A) || (vga_io_addr_i == VGA_PAL_B) ||
                                (vga_io_addr_i == VGA_PAL_C));

    assign cfg_rsp_o            = st.rsp;
    assign error_msg_o          = st.msg;
    assign error_msg_fatal_o    = st.msg_fatal;
    assign system_error_out_n_o = st.serr_n;
    assign system_error_oe_o    = !st.serr_n;   // open drain: drive only while asserting
endmodule
`default_nettype wire

// ===== sim/bcr_config_props.sv
// bcr_config_props: port-level assertions of the configuration block
`timescale 1ns/1ps
`default_nettype none
module bcr_config_props #(
    parameter logic [15:0]              VENDOR_CODE  = 16'h1A2B,
    parameter logic [15:0]              PRODUCT_CODE = 16'h3C4D
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   hot_rst_i,
    input  wire bcr_pkg::bcr_cfg_req_t  cfg_req_i,
    input  wire bcr_pkg::bcr_cfg_rsp_t  cfg_rsp_o,
    input  wire logic                   vga_io_write_i,
    input  wire logic [9:0]             vga_io_addr_i,
    input  wire logic                   vga_palette_hit_o,
    input  wire logic                   error_event_i,
    input  wire logic                   error_fatal_i,
    input  wire logic                   error_msg_o,
    input  wire logic                   error_msg_fatal_o,
    input  wire logic                   system_error_out_n_o,
    input  wire logic                   system_error_oe_o,
    input  wire bcr_pkg::bcr_ctrl_t     ctrl_o
);
    import bcr_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // every access, mapped or not, gets exactly one answer one cycle later
    property p_ack; cfg_rsp_o.ack == $past(cfg_req_i.valid); endproperty
    a_ack: assert property (p_ack) else $error("answer not one cycle after request");
    property p_ident; cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr[11:2] == 10'h000
        |=> cfg_rsp_o.rdata == {PRODUCT_CODE, VENDOR_CODE}; endproperty
    a_ident: assert property (p_ident) else $error("identification dword wrong");
    property p_ro; cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr[11:2] == 10'h001
        |=> (cfg_rsp_o.rdata[7:3] & 5'h13) == 5'h00; endproperty
    a_ro: assert property (p_ro) else $error("fixed-zero command bit set");
    property p_wr; cfg_req_i.valid && cfg_req_i.write |=> cfg_rsp_o.rdata == 32'h0000_0000; endproperty
    a_wr: assert property (p_wr) else $error("write answer carries data");
    // the io enable may only move after a low-byte command write or a hot reset
    property p_io; $changed(ctrl_o.io_target_en) |-> $past(hot_rst_i) || $past(cfg_req_i.valid
        && cfg_req_i.write && cfg_req_i.addr[11:2] == 10'h001 && cfg_req_i.be[0]); endproperty
    a_io: assert property (p_io) else $error("io enable moved without cause");
    property p_bme; ctrl_o.secondary_target_en == ctrl_o.primary_master_en
        && (!ctrl_o.primary_master_en || ctrl_o.split_cpl_en); endproperty
    a_bme: assert property (p_bme) else $error("master enable fan-out wrong");
    property p_msg; error_msg_o |-> $past(error_event_i) && system_error_out_n_o
        && error_msg_fatal_o == $past(error_fatal_i); endproperty
    a_msg: assert property (p_msg) else $error("error message without event");
    property p_serr; system_error_oe_o == !system_error_out_n_o
        && (system_error_out_n_o || $past(error_event_i)); endproperty
    a_serr: assert property (p_serr) else $error("system error pin wrong");
    property p_vga; vga_palette_hit_o |-> vga_io_write_i
        && vga_io_addr_i inside {10'h3C6, 10'h3C8, 10'h3C9}; endproperty
    a_vga: assert property (p_vga) else $error("palette hit off palette");
endmodule
`default_nettype wire

// ===== sim/bcr_host_model.sv
// bcr_host_model: configuration host issuing one access at a time
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model (
    input  wire logic                   clk_i,
    input  wire bcr_pkg::bcr_cfg_rsp_t  cfg_rsp_i,
    output var bcr_pkg::bcr_cfg_req_t   cfg_req_o
);
    import bcr_pkg::*;
    initial cfg_req_o = '0;
    // hold the request over its taking edge; released fields show inverted junk, not stale values
    task automatic cfg(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk_i);
        #5 cfg_req_o = '{1'b1, w, a, be, d};
        @(posedge clk_i);
        #5 cfg_req_o = '{1'b0, ~w, ~a, ~be, ~d};
        ok = 1'b0;
        q = '0;
        // bounded look for the answer
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_rsp_i.ack === 1'b1) begin
                ok = 1'b1;
                q = cfg_rsp_i.rdata;
            end else begin
                @(posedge clk_i);
                #5;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== sim/test_bridge_config_header_command.sv
// test_bridge_config_header_command: self-checking bench of the configuration block
`timescale 1ns/1ps
`default_nettype none
module test_bridge_config_header_command;
    import bcr_pkg::*;
    localparam logic [15:0] VC = 16'h5A5A;  // arbitrary value
    localparam logic [15:0] PC = 16'hC3C3;  // arbitrary value
    logic clk_i = 0, rst_n_i = 0, hot_rst_i = 0, reverse_mode_i = 0, pcix_mode_i = 0, vga_io_write_i = 0;
    logic parity_event_i = 0, error_event_i = 0, error_fatal_i = 0, vga_palette_hit_o, error_msg_o;
    logic error_msg_fatal_o, system_error_out_n_o, system_error_oe_o;
    logic [9:0] vga_io_addr_i = '0;
    logic [31:0] seed = 32'h0000_0049, r;
    bcr_cfg_req_t cfg_req_i;
    bcr_cfg_rsp_t cfg_rsp_o;
    bcr_ctrl_t ctrl_o;
    int cmd = 0, mdpe = 0, miscompares = 0, n_tests = 0, i;
    always #25 clk_i = ~clk_i;
    bcr_config #(.VENDOR_CODE(VC), .PRODUCT_CODE(PC)) u_bcr_config (.clk_i, .rst_n_i, .hot_rst_i, .cfg_req_i,
        .cfg_rsp_o, .reverse_mode_i, .pcix_mode_i, .vga_io_write_i, .vga_io_addr_i, .vga_palette_hit_o,
        .parity_event_i, .error_event_i, .error_fatal_i, .error_msg_o, .error_msg_fatal_o,
        .system_error_out_n_o, .system_error_oe_o, .ctrl_o);
    bcr_host_model u_bcr_host_model (.clk_i, .cfg_rsp_i(cfg_rsp_o), .cfg_req_o(cfg_req_i));
    // model: bit5 only writable in reverse mode, bits 3,4,7 stay zero
    function automatic void mwr(logic [3:0] be, logic [31:0] d);
        if (be[0]) cmd = (cmd & 32'h100) | (d & (reverse_mode_i ? 32'h67 : 32'h47));
        if (be[1]) cmd = (cmd & 32'hFF) | (d & 32'h100);
        if (be[3] && d[24]) mdpe = 0;
    endfunction
    function automatic logic [31:0] e4();
        return 32'(cmd) | (32'(mdpe) << 24);
    endfunction
    function automatic logic [31:0] ectl();
        return {26'h0, cmd[0], cmd[1], cmd[2], cmd[2], cmd[2] | (reverse_mode_i & pcix_mode_i), cmd[6]};
    endfunction
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic end_sim();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // one access through the host; a missing answer ends the run
    task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        logic ok;
        if (w && a[11:2] == 10'h001) mwr(be, d);
        u_bcr_host_model.cfg(w, a, be, d, q, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        chk(q, w ? 32'h0 : (a[11:2] == 10'h000 ? {PC, VC} : (a[11:2] == 10'h001 ? e4() : 32'h0)));
    endtask
    task automatic pulse_err(input logic f);
        @(posedge clk_i);
        #5 error_event_i = 1;
        error_fatal_i = f;
        @(posedge clk_i);
        #5 error_event_i = 0;
        chk({error_msg_o, error_msg_fatal_o, system_error_out_n_o, system_error_oe_o},
            {!reverse_mode_i && cmd[8], !reverse_mode_i && cmd[8] && f, !(reverse_mode_i && cmd[8]),
             reverse_mode_i && cmd[8]});
    endtask
    initial begin
        #1000000 miscompares++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        #5 rst_n_i = 1;
        acc(0, 12'h000, 4'hF, 0);
        acc(0, 12'h004, 4'hF, 0);
        chk(ctrl_o, ectl());
        acc(1, 12'h004, 4'hF, '1);
        acc(0, 12'h004, 4'hF, 0);
        acc(1, 12'h000, 4'hF, '1);
        acc(0, 12'h002, 4'hF, 0);
        acc(1, 12'h100, 4'hF, '1);
        acc(0, 12'h103, 4'hF, 0);
        $display("test 1 done");
        repeat (20) begin
            r = xs();
            acc(1, 12'h004, r[27:24], r);
            acc(0, 12'h004, 4'hF, 0);
            chk(ctrl_o, ectl());
        end
        $display("test 2 done");
        // parity status with and without its enable, then zero and one writes to it
        for (i = 0; i < 2; i++) begin
            acc(1, 12'h004, 4'h1, i << 6);
            @(posedge clk_i);
            #5 parity_event_i = 1;
            @(posedge clk_i);
            #5 parity_event_i = 0;
            mdpe |= cmd[6];
            acc(0, 12'h004, 4'hF, 0);
            acc(1, 12'h004, 4'h8, 0);
            acc(0, 12'h004, 4'hF, 0);
            acc(1, 12'h004, 4'h8, 32'h0100_0000);
            acc(0, 12'h004, 4'hF, 0);
        end
        $display("test 3 done");
        // odd passes set the error enable and the fatal qualifier so the fatal message is seen forward and the pin in reverse
        for (i = 0; i < 4; i++) begin
            acc(1, 12'h004, 4'h2, (i & 1) << 8);
            pulse_err(i[0]);
            if (i == 1) begin
                reverse_mode_i = 1;
                pcix_mode_i = 1;
                repeat (3) @(posedge clk_i);
                #5 chk(ctrl_o, ectl());
            end
        end
        $display("test 4 done");
        acc(1, 12'h004, 4'h1, 32'h20);
        acc(0, 12'h004, 4'hF, 0);
        @(posedge clk_i);
        for (i = 0; i < 5; i++) begin
            #5 vga_io_write_i = i < 4;
            vga_io_addr_i = 10'h3C6 + 10'(i % 4);
            #1 chk(vga_palette_hit_o, i != 1 && i < 4);
            @(posedge clk_i);
        end
        #5 hot_rst_i = 1;
        vga_io_write_i = 0;
        @(posedge clk_i);
        #5 hot_rst_i = 0;
        cmd = 0;
        mdpe = 0;
        acc(0, 12'h004, 4'hF, 0);
        $display("test 5 done");
        end_sim();
    end
endmodule
bind bcr_config bcr_config_props #(.VENDOR_CODE(VENDOR_CODE), .PRODUCT_CODE(PRODUCT_CODE)) u_bcr_config_props (
    .clk_i, .rst_n_i, .hot_rst_i, .cfg_req_i, .cfg_rsp_o, .vga_io_write_i, .vga_io_addr_i, .vga_palette_hit_o,
    .error_event_i, .error_fatal_i, .error_msg_o, .error_msg_fatal_o, .system_error_out_n_o,
    .system_error_oe_o, .ctrl_o);
`default_nettype wire
